// File: core/analog_comparator_control.sv
// The AXI4-Lite register port was decided locally.
`default_nettype none
// Overview of operation
// R01 - Result bit is one when positive input exceeds negative input.
// R02 - Mux enabled and converter off: channel select picks channel 0 to 7.
// R03 - Mux disabled or converter on: dedicated negative pin is used.
// R04 - Software clears converter power reduction before using the channel mux.
// R05 - Power-off bit 7 removes comparator power; zero keeps it on.
// R06 - Bandgap bit 6 picks internal reference, else positive pin.
// R07 - Raw output is synchronised into result bit 5, one to two cycles.
// R08 - Flag bit 4 is set by hardware on the selected event.
// R09 - Flag is cleared when the interrupt vector is taken.
// R10 - Writing one clears the flag; writing zero leaves it.
// R11 - Request only with flag, enable bit 3 and global enable set.
// R12 - Mode bits 1:0: toggle, reserved, falling, rising.
// R13 - Capture bit 2 routes output to capture timer front end.
// R14 - Software also sets the capture timer interrupt enable.
// R15 - Software clears interrupt enable before changing power-off or mode.
// R16 - Pin input-off bits 1:0 kill buffers; port bit reads zero.
// R17 - Bits 7:2 of the pin input-off register read zero.
// R18 - Software should set input-off bits on analog-only pins.
// R19 - Edges compare current synchronised output with previous cycle.
// R20 - Reserved mode 01 produces no event.
module analog_comparator_control
  import comparator_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, low
  input wire logic [ADDR_W-1:0] awaddr, // Write address
  input wire logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input wire logic [31:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Write strobes
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data ready
  output logic [1:0] bresp, // Write response
  output logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  input wire logic [ADDR_W-1:0] araddr, // Read address
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address ready
  output logic [31:0] rdata, // Read data
  output logic [1:0] rresp, // Read response
  output logic rvalid, // Read data valid
  input wire logic rready, // Read data ready
  input wire logic comparator_raw, // Analog comparator output
  input wire logic converter_enable, // Converter switched on
  input wire logic [2:0] channel_select, // Converter channel select
  input wire logic global_irq_enable, // CPU global interrupt enable
  input wire logic irq_vector_taken, // Vector executed pulse
  input wire logic [1:0] pin_raw, // Pin levels, negative/positive
  output logic comparator_power_off, // Comparator power removed
  output logic bandgap_select, // Bandgap on positive input
  output logic neg_from_channel, // Negative input from channel
  output logic [2:0] neg_channel, // Channel for negative input
  output logic capture_input, // Feed to capture front end
  output logic irq_request, // Comparator interrupt request
  output logic [1:0] pin_input_off, // Digital buffers off
  output logic [1:0] pin_read, // Port input bits
  output logic [2:0] trigger_source_select // Converter trigger source
);

  if (ADDR_W < 9)
  begin : g_bad_width
    $error("ADDR_W too small for register map");
  end

  comp_event_if ev ();

  comparator_event_detect u_detect (
    .aclk(aclk),
    .aresetn(aresetn),
    .ev(ev.det)
  );

  logic [7:0] ctrl_ff, nxt_ctrl;
  logic mux_en_ff, nxt_mux_en;
  logic [2:0] trig_ff, nxt_trig;
  logic [1:0] pin_off_ff, nxt_pin_off;
  wr_state_t wr_state_ff, nxt_wr_state;
  logic [ADDR_W-1:0] aw_addr_ff, nxt_aw_addr;
  logic [31:0] w_data_ff, nxt_w_data;
  logic w_strb0_ff, nxt_w_strb0;
  logic awready_ff, nxt_awready;
  logic wready_ff, nxt_wready;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic arready_ff, nxt_arready;
  logic rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;
  logic neg_from_channel_ff, nxt_neg_from_channel;
  logic [2:0] neg_channel_ff, nxt_neg_channel;
  logic capture_ff, nxt_capture;
  logic irq_request_ff, nxt_irq_request;
  logic [1:0] pin_read_ff, nxt_pin_read;
  logic aw_hs, w_hs, do_write, flag_clear;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic wr_strb0;

  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
    return addr == ADDR_W'(reg_addr(idx));
  endfunction : hit

  function automatic logic mapped(input logic [ADDR_W-1:0] addr);
    return hit(addr, CTRL_IDX) || hit(addr, CONV_B_IDX) || hit(addr, PIN_OFF_IDX);
  endfunction : mapped

  // ----------------------------------------
  // Write channel
  // ----------------------------------------
  always_comb
  begin
    aw_hs = awvalid && awready_ff;
    w_hs = wvalid && wready_ff;
    nxt_wr_state = wr_state_ff;
    nxt_aw_addr = aw_hs ? awaddr : aw_addr_ff;
    nxt_w_data = w_hs ? wdata : w_data_ff;
    nxt_w_strb0 = w_hs ? wstrb[0] : w_strb0_ff;
    do_write = 1'b0;
    case (wr_state_ff)
      WR_IDLE:
      begin
        if (aw_hs && w_hs)
          nxt_wr_state = WR_RESP;
        else if (aw_hs)
          nxt_wr_state = WR_GOT_ADDR;
        else if (w_hs)
          nxt_wr_state = WR_GOT_DATA;
        do_write = aw_hs && w_hs;
      end
      WR_GOT_ADDR:
      begin
        if (w_hs)
          nxt_wr_state = WR_RESP;
        do_write = w_hs;
      end
      WR_GOT_DATA:
      begin
        if (aw_hs)
          nxt_wr_state = WR_RESP;
        do_write = aw_hs;
      end
      WR_RESP:
      begin
        if (bready)
          nxt_wr_state = WR_IDLE;
      end
      default: nxt_wr_state = WR_IDLE;
    endcase
    wr_addr = aw_hs ? awaddr : aw_addr_ff;
    wr_data = w_hs ? wdata : w_data_ff;
    wr_strb0 = w_hs ? wstrb[0] : w_strb0_ff;
    nxt_awready = nxt_wr_state == WR_IDLE || nxt_wr_state == WR_GOT_DATA;
    nxt_wready = nxt_wr_state == WR_IDLE || nxt_wr_state == WR_GOT_ADDR;
    nxt_bvalid = nxt_wr_state == WR_RESP;
    nxt_bresp = bresp_ff;
    if (do_write)
      nxt_bresp = mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
  end

  // ----------------------------------------
  // Registers, flag and outputs
  // ----------------------------------------
  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    nxt_mux_en = mux_en_ff;
    nxt_trig = trig_ff;
    nxt_pin_off = pin_off_ff;
    flag_clear = irq_vector_taken; // [R09]
    if (do_write && wr_strb0)
    begin
      if (hit(wr_addr, CTRL_IDX))
      begin
        nxt_ctrl[BIT_POWER_OFF] = wr_data[BIT_POWER_OFF]; // [R05]
        nxt_ctrl[BIT_BANDGAP] = wr_data[BIT_BANDGAP]; // [R06]
        nxt_ctrl[BIT_IRQ_EN] = wr_data[BIT_IRQ_EN];
        nxt_ctrl[BIT_CAPTURE] = wr_data[BIT_CAPTURE];
        nxt_ctrl[MODE_HI:MODE_LO] = wr_data[MODE_HI:MODE_LO];
        flag_clear = flag_clear || wr_data[BIT_FLAG]; // [R10]
      end
      if (hit(wr_addr, CONV_B_IDX))
      begin
        nxt_mux_en = wr_data[BIT_MUX_EN];
        nxt_trig = wr_data[TRIG_HI:TRIG_LO];
      end
      if (hit(wr_addr, PIN_OFF_IDX))
        nxt_pin_off = wr_data[PIN_OFF_HI:PIN_OFF_LO];
    end
    // Hardware set wins over a clear in the same cycle
    nxt_ctrl[BIT_FLAG] = ev.event_hit || (ctrl_ff[BIT_FLAG] && !flag_clear); // [R08] [R09] [R10]
    nxt_ctrl[BIT_RESULT] = 1'b0;
    nxt_irq_request = nxt_ctrl[BIT_FLAG] && nxt_ctrl[BIT_IRQ_EN] && global_irq_enable; // [R11]
    nxt_capture = nxt_ctrl[BIT_CAPTURE] && ev.result; // [R13]
    nxt_neg_from_channel = nxt_mux_en && !converter_enable; // [R02] [R03]
    nxt_neg_channel = channel_select; // [R02]
    nxt_pin_read = pin_raw & ~nxt_pin_off; // [R16]
  end

  assign ev.raw = comparator_raw; // [R01]
  assign ev.mode = irq_mode_t'(ctrl_ff[MODE_HI:MODE_LO]); // [R12]

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  always_comb
  begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (rvalid_ff && rready)
      nxt_rvalid = 1'b0;
    if (arvalid && arready_ff)
    begin
      nxt_rvalid = 1'b1;
      nxt_rdata = 32'h0000_0000;
      nxt_rresp = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      if (hit(araddr, CTRL_IDX))
      begin
        nxt_rdata[7:0] = ctrl_ff;
        nxt_rdata[BIT_RESULT] = ev.result; // [R07]
      end
      if (hit(araddr, CONV_B_IDX))
      begin
        nxt_rdata[BIT_MUX_EN] = mux_en_ff;
        nxt_rdata[TRIG_HI:TRIG_LO] = trig_ff;
      end
      if (hit(araddr, PIN_OFF_IDX))
        nxt_rdata[PIN_OFF_HI:PIN_OFF_LO] = pin_off_ff; // [R17]
    end
    nxt_arready = !nxt_rvalid;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_ff <= CTRL_RESET;
      mux_en_ff <= CONV_B_RESET[BIT_MUX_EN];
      trig_ff <= CONV_B_RESET[TRIG_HI:TRIG_LO];
      pin_off_ff <= PIN_OFF_RESET[PIN_OFF_HI:PIN_OFF_LO];
      wr_state_ff <= WR_IDLE;
      aw_addr_ff <= '0;
      w_data_ff <= 32'h0000_0000;
      w_strb0_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
      neg_from_channel_ff <= 1'b0;
      neg_channel_ff <= 3'h0;
      capture_ff <= 1'b0;
      irq_request_ff <= 1'b0;
      pin_read_ff <= 2'h0;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      mux_en_ff <= nxt_mux_en;
      trig_ff <= nxt_trig;
      pin_off_ff <= nxt_pin_off;
      wr_state_ff <= nxt_wr_state;
      aw_addr_ff <= nxt_aw_addr;
      w_data_ff <= nxt_w_data;
      w_strb0_ff <= nxt_w_strb0;
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
      neg_from_channel_ff <= nxt_neg_from_channel;
      neg_channel_ff <= nxt_neg_channel;
      capture_ff <= nxt_capture;
      irq_request_ff <= nxt_irq_request;
      pin_read_ff <= nxt_pin_read;
    end
  end

  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
  assign comparator_power_off = ctrl_ff[BIT_POWER_OFF]; // [R05]
  assign bandgap_select = ctrl_ff[BIT_BANDGAP]; // [R06]
  assign neg_from_channel = neg_from_channel_ff;
  assign neg_channel = neg_channel_ff;
  assign capture_input = capture_ff;
  assign irq_request = irq_request_ff;
  assign pin_input_off = pin_off_ff;
  assign pin_read = pin_read_ff;
  assign trigger_source_select = trig_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_wr_both;
    awvalid && awready_ff && wvalid && wready_ff;
  endsequence

  chk_write_resp: assert property (s_wr_both |=> bvalid_ff)
    else $error("no write response after write");
  chk_flag_set_wins: assert property (ev.event_hit |=> ctrl_ff[BIT_FLAG]) // [R08]
    else $error("event did not set flag");
  chk_vector_clears: assert property (irq_vector_taken && !ev.event_hit |=> !ctrl_ff[BIT_FLAG]) // [R09]
    else $error("vector did not clear flag");
  chk_irq_gate: assert property (irq_request_ff |-> ctrl_ff[BIT_FLAG] && ctrl_ff[BIT_IRQ_EN]
      && $past(global_irq_enable)) // [R11]
    else $error("request without flag and enables");
  chk_neg_dedicated: assert property (neg_from_channel_ff |-> !$past(converter_enable)) // [R03]
    else $error("channel used while converter on");
  chk_channel_follow: assert property (##1 neg_channel_ff == $past(channel_select)) // [R02]
    else $error("negative channel mismatch");
  chk_pin_read_zero: assert property ((pin_read_ff & pin_off_ff) == 2'h0) // [R16]
    else $error("disabled pin reads one");

endmodule : analog_comparator_control
`default_nettype wire

// File: core/comp_event_if.sv
`default_nettype none
interface comp_event_if;
  import comparator_pkg::*;
  logic raw;
  irq_mode_t mode;
  logic result;
  logic event_hit;
  modport det (input raw, input mode, output result, output event_hit);
  modport ctl (output raw, output mode, input result, input event_hit);
endinterface : comp_event_if
`default_nettype wire

// File: core/comparator_event_detect.sv
`default_nettype none
module comparator_event_detect
  import comparator_pkg::*;
(
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, low
  comp_event_if.det ev // Raw in, result and event out
);

  logic sync1_ff;
  logic sync2_ff;
  logic prev_ff;
  logic nxt_sync1;
  logic nxt_sync2;
  logic nxt_prev;

  // ----------------------------------------
  // Synchroniser and history
  // ----------------------------------------
  always_comb
  begin
    nxt_sync1 = ev.raw;
    nxt_sync2 = sync1_ff; // [R07]
    nxt_prev = sync2_ff; // [R19]
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      prev_ff <= 1'b0;
    end
    else
    begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
      prev_ff <= nxt_prev;
    end
  end

  assign ev.result = sync2_ff; // [R01] [R07]

  // ----------------------------------------
  // Event select
  // ----------------------------------------
  always_comb
  begin
    case (ev.mode)
      MODE_TOGGLE: ev.event_hit = sync2_ff ^ prev_ff; // [R12] [R19]
      MODE_FALL: ev.event_hit = prev_ff & ~sync2_ff; // [R12]
      MODE_RISE: ev.event_hit = ~prev_ff & sync2_ff; // [R12]
      MODE_RESERVED: ev.event_hit = 1'b0; // [R20]
      default: ev.event_hit = 1'b0;
    endcase
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_reserved_mode_quiet: assert property (ev.mode == MODE_RESERVED |-> !ev.event_hit) // [R20]
    else $error("event raised in reserved mode");
  chk_rise_event_seen: assert property (ev.mode == MODE_RISE && $rose(ev.result) |-> ev.event_hit) // [R12]
    else $error("rising edge missed");

endmodule : comparator_event_detect
`default_nettype wire

// File: core/comparator_pkg.sv
`default_nettype none
package comparator_pkg;

  // ----------------------------------------
  // Register indices (byte address = 4 x index)
  // ----------------------------------------
  localparam logic [7:0] CTRL_IDX = 8'h50;
  localparam logic [7:0] CONV_B_IDX = 8'h7B;
  localparam logic [7:0] PIN_OFF_IDX = 8'h7F;

  // ----------------------------------------
  // Control/status field positions
  // ----------------------------------------
  localparam int BIT_POWER_OFF = 7;
  localparam int BIT_BANDGAP = 6;
  localparam int BIT_RESULT = 5;
  localparam int BIT_FLAG = 4;
  localparam int BIT_IRQ_EN = 3;
  localparam int BIT_CAPTURE = 2;
  localparam int MODE_HI = 1;
  localparam int MODE_LO = 0;
  localparam int BIT_MUX_EN = 6;
  localparam int TRIG_HI = 2;
  localparam int TRIG_LO = 0;
  localparam int PIN_OFF_HI = 1;
  localparam int PIN_OFF_LO = 0;

  // ----------------------------------------
  // Reset values and bus answers
  // ----------------------------------------
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CONV_B_RESET = 8'h00;
  localparam logic [7:0] PIN_OFF_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_TOGGLE = 2'h0,
    MODE_RESERVED = 2'h1,
    MODE_FALL = 2'h2,
    MODE_RISE = 2'h3
  } irq_mode_t;

  typedef enum logic [1:0] {
    WR_IDLE = 2'h0,
    WR_GOT_ADDR = 2'h1,
    WR_RESP = 2'h3,
    WR_GOT_DATA = 2'h2
  } wr_state_t;

  function automatic logic [11:0] reg_addr(input logic [7:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction : reg_addr

endpackage : comparator_pkg
`default_nettype wire

// File: dv/comparator_core_model.sv
`default_nettype none
module comparator_core_model
#(
  parameter int BANDGAP_MV = 1100,
  parameter int NEG_PIN_MV = 500,
  parameter int LOW_CH_MV = 50,
  parameter int HIGH_CH_MV = 900
)
(
  input wire logic aclk, // System clock
  input wire logic bandgap_select, // Bandgap on positive input
  input wire logic neg_from_channel, // Negative input from channel
  input wire logic [2:0] neg_channel, // Channel for negative input
  input wire logic comparator_power_off, // Comparator unpowered
  input wire logic capture_input, // Capture front end feed
  input var int pos_mv, // Positive pin voltage
  output var logic comparator_raw, // Raw comparator output
  output var int capture_count // Rising edges seen at capture
);
  timeunit 1ns;
  timeprecision 1ps;
  int pos_v;
  int neg_v;
  int cnt = 0;
  logic cap_prev = 1'h0;

  // ----------------------------------------
  // Analog core
  // ----------------------------------------
  always_comb
  begin
    pos_v = bandgap_select ? BANDGAP_MV : pos_mv;
    neg_v = NEG_PIN_MV;
    if (neg_from_channel)
      neg_v = (neg_channel == 3'h3) ? LOW_CH_MV : HIGH_CH_MV;
    comparator_raw = comparator_power_off ? 1'h0 : (pos_v > neg_v);
  end

  // ----------------------------------------
  // Capture front end
  // ----------------------------------------
  always @(posedge aclk)
  begin
    cap_prev <= capture_input;
    if (capture_input && !cap_prev)
      cnt <= cnt + 1;
  end
  assign capture_count = cnt;
endmodule : comparator_core_model
`default_nettype wire

// File: dv/tb_top.sv
`default_nettype none
module tb_top import comparator_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_CTRL = {2'h0, CTRL_IDX, 2'h0};
  localparam logic [11:0] A_CONV = {2'h0, CONV_B_IDX, 2'h0};
  localparam logic [11:0] A_PIN = {2'h0, PIN_OFF_IDX, 2'h0};
  logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0, converter_enable = 1'h0;
  logic global_irq_enable = 1'h0, irq_vector_taken = 1'h0;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic [2:0] channel_select = 3'h0;
  logic [1:0] pin_raw = 2'h3;
  logic awready, wready, bvalid, arready, rvalid, comparator_raw;
  logic comparator_power_off, bandgap_select, neg_from_channel, capture_input, irq_request;
  logic [31:0] rdata, rdv;
  logic [1:0] bresp, rresp, rsp, pin_input_off, pin_read;
  logic [2:0] neg_channel, trigger_source_select;
  int fail_count = 0;
  int cmp_count = 0;
  int pos_mv = 100;
  int capture_count;

  analog_comparator_control uut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .comparator_raw, .converter_enable, .channel_select, .global_irq_enable,
    .irq_vector_taken, .pin_raw, .comparator_power_off, .bandgap_select,
    .neg_from_channel, .neg_channel, .capture_input, .irq_request, .pin_input_off,
    .pin_read, .trigger_source_select
  );

  comparator_core_model core (
    .aclk, .bandgap_select, .neg_from_channel, .neg_channel, .comparator_power_off,
    .capture_input, .pos_mv, .comparator_raw, .capture_count
  );

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (awready === 1'h1)
        awvalid <= 1'h0;
      if (wready === 1'h1)
        wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    rsp = bresp;
    bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (arready === 1'h1)
        arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rdv = rdata;
    rsp = rresp;
    rready <= 1'h0;
  endtask : rd

  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize

  // ----------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------
  initial
  begin
    forever #4 aclk = ~aclk;
  end

  initial
  begin
    #200000;
    fail_count++;
    summarize();
  end

  initial
  begin
    tick(5);
    aresetn <= 1'h1;
    tick(2);
    rd(A_CTRL);
    chk(rdv, 32'h0);
    rd(A_CONV);
    chk(rdv, 32'h0);
    rd(12'h0);
    chk(32'(rsp), 32'(RESP_SLVERR));
    chk(rdv, 32'h0);
    wr(12'h4, 32'hFF);
    chk(32'(rsp), 32'(RESP_SLVERR));
    $display("test registers done");
    // Reserved mode keeps the flag quiet here
    wr(A_CTRL, 32'h41);
    tick(4);
    rd(A_CTRL);
    chk(rdv, 32'h61);
    chk(32'(bandgap_select), 32'h1);
    wr(A_CTRL, 32'hC1);
    tick(4);
    rd(A_CTRL);
    chk(rdv, 32'hC1);
    chk(32'(comparator_power_off), 32'h1);
    wr(A_CTRL, 32'h01);
    $display("test inputs done");
    // Converter power reduction taken as already cleared
    wr(A_CONV, 32'h45);
    rd(A_CONV);
    chk(rdv, 32'h45);
    chk(32'(trigger_source_select), 32'h5);
    // Byte lane 0 off: write answered but ignored
    wstrb <= 4'hE;
    wr(A_CONV, 32'h0);
    chk(32'(rsp), 32'(RESP_OKAY));
    wstrb <= 4'hF;
    rd(A_CONV);
    chk(rdv, 32'h45);
    for (int ch = 0; ch < 8; ch++)
    begin
      channel_select <= ch[2:0];
      tick(4);
      chk(32'(neg_from_channel), 32'h1);
      chk(32'(neg_channel), 32'(ch[2:0]));
      rd(A_CTRL);
      chk(rdv, {24'h0, 2'h0, (ch == 3), 3'h0, 2'h1});
    end
    converter_enable <= 1'h1;
    tick(2);
    chk(32'(neg_from_channel), 32'h0);
    converter_enable <= 1'h0;
    wr(A_CONV, 32'h0);
    tick(2);
    chk(32'(neg_from_channel), 32'h0);
    $display("test mux done");
    // Timer capture interrupt enable lives in the timer
    pos_mv <= 900;
    tick(4);
    wr(A_CTRL, 32'h05);
    tick(3);
    chk(32'(capture_input), 32'h1);
    chk(capture_count, 32'h1);
    wr(A_CTRL, 32'h01);
    tick(3);
    chk(32'(capture_input), 32'h0);
    pos_mv <= 100;
    tick(4);
    $display("test capture done");
    // Interrupt enable stays clear while the mode changes
    for (int m = 0; m < 4; m++)
    begin
      wr(A_CTRL, {30'h4, m[1:0]});
      pos_mv <= 900;
      tick(5);
      rd(A_CTRL);
      chk(rdv, {24'h0, 3'h1, (m == 0 || m == 3), 2'h0, m[1:0]});
      wr(A_CTRL, {30'h4, m[1:0]});
      pos_mv <= 100;
      tick(5);
      rd(A_CTRL);
      chk(rdv, {24'h0, 3'h0, (m == 0 || m == 2), 2'h0, m[1:0]});
    end
    $display("test modes done");
    wr(A_CTRL, 32'h0B);
    global_irq_enable <= 1'h1;
    pos_mv <= 900;
    tick(6);
    chk(32'(irq_request), 32'h1);
    wr(A_CTRL, 32'h0B);
    rd(A_CTRL);
    chk(rdv, 32'h3B);
    global_irq_enable <= 1'h0;
    tick(3);
    chk(32'(irq_request), 32'h0);
    global_irq_enable <= 1'h1;
    wr(A_CTRL, 32'h03);
    tick(3);
    chk(32'(irq_request), 32'h0);
    wr(A_CTRL, 32'h0B);
    tick(3);
    chk(32'(irq_request), 32'h1);
    irq_vector_taken <= 1'h1;
    tick(1);
    irq_vector_taken <= 1'h0;
    tick(3);
    chk(32'(irq_request), 32'h0);
    rd(A_CTRL);
    chk(rdv, 32'h2B);
    $display("test interrupt done");
    // Both pins carry analog levels here
    wr(A_PIN, 32'hFF);
    rd(A_PIN);
    chk(rdv, 32'h3);
    tick(2);
    chk(32'(pin_input_off), 32'h3);
    chk(32'(pin_read), 32'h0);
    wr(A_PIN, 32'h1);
    tick(3);
    chk(32'(pin_read), 32'h2);
    $display("test pins done");
    summarize();
  end
endmodule : tb_top
`default_nettype wire
